// ===== dac_cmd_chk.sv
`timescale 1ns/10ps

// ========
// command outcome checks
module dac_cmd_chk
	import dac_cmd_pkg::*;
(
	input wire logic       clk,
	input wire logic       srst,
	input wire code_arr_t  stored_code,
	input wire code_arr_t  output_code,
	input wire logic [7:0] output_load,
	input wire logic       write_through_mode,
	input wire cmd_e       last_command,
	input wire logic       command_done,
	input wire logic       frame_aborted
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	rst_clear_a: assert property ($fell(srst) |-> stored_code == '0 && output_code == '0)
		else $error("codes not clear after reset");
	load_done_a: assert property (|output_load |-> command_done)
		else $error("output loaded without a command");
	wr_noload_a: assert property (command_done && !last_command[3] && !write_through_mode
		|-> output_load == 8'h00) else $error("register-only write moved an output");
	wt_load_a: assert property (command_done && !last_command[3] && write_through_mode
		|-> output_load == (8'h01 << last_command[2:0])) else $error("write-through load wrong");
	mode_cause_a: assert property ($changed(write_through_mode) |-> command_done
		&& last_command inside {CMD_REGISTER_ONLY, CMD_WRITE_THROUGH}) else $error("mode moved");
	wt_set_a: assert property (command_done && last_command == CMD_WRITE_THROUGH
		|-> write_through_mode) else $error("write-through not entered");
	wr_set_a: assert property (command_done && last_command == CMD_REGISTER_ONLY
		|-> !write_through_mode) else $error("register-only not entered");
	all_load_a: assert property (command_done && last_command inside {CMD_CHANNEL_ONE,
		CMD_BROADCAST} |-> output_load == 8'hff && output_code == stored_code)
		else $error("full update wrong");
	abort_quiet_a: assert property (frame_aborted |-> !command_done && output_load == 8'h00
		&& $stable(stored_code)) else $error("aborted frame had an effect");
endmodule

bind octal_dac_command_update_logic dac_cmd_chk i_chk (.clk(clk), .srst(srst),
	.stored_code(stored_code), .output_code(output_code), .output_load(output_load),
	.write_through_mode(write_through_mode), .last_command(last_command),
	.command_done(command_done), .frame_aborted(frame_aborted));

// ===== dac_cmd_pkg.sv
package dac_cmd_pkg;

	// ==========================================================
	// frame geometry
	localparam int FRAME_BITS  = 16;
	localparam int MIN_EDGES   = 15;
	localparam int EDGE_CNT_W  = 5;
	localparam int NUM_CH      = 8;
	localparam int CODE_W      = 12;

	// ==========================================================
	// field positions inside the command word
	localparam int CMD_MSB     = 15;
	localparam int CMD_LSB     = 12;
	localparam int KIND_BIT    = 15;
	localparam int CH_MSB      = 14;
	localparam int CH_LSB      = 12;
	localparam int CODE_MSB    = 11;
	localparam int REG_HI_BIT  = 11;
	localparam int REG_LO_BIT  = 10;
	localparam int SEL_MSB     = 7;

	// ==========================================================
	// values after reset
	localparam logic [CODE_W-1:0]     CODE_RST  = 12'h000;
	localparam logic [FRAME_BITS-1:0] WORD_RST  = 16'h0000;
	localparam logic [EDGE_CNT_W-1:0] EDGES_RST = 5'h00;
	localparam logic                  MODE_RST  = 1'b0;
	localparam logic                  REG_RST   = 1'b0;
	localparam logic [7:0]            STAT_RST  = 8'h00;

	// regulator field encodings
	localparam logic [1:0] REGULATOR_OFF = 2'b00;
	localparam logic [1:0] REGULATOR_ON  = 2'b10;

	typedef enum logic [3:0] {
		CMD_REGISTER_ONLY = 4'b1000,
		CMD_WRITE_THROUGH = 4'b1001,
		CMD_UPDATE_SELECT = 4'b1010,
		CMD_CHANNEL_ONE   = 4'b1011,
		CMD_BROADCAST     = 4'b1100
	} cmd_e;

	typedef logic [NUM_CH-1:0][CODE_W-1:0] code_arr_t;

endpackage

// ===== frame_host.sv
`timescale 1ns/10ps

// ========
// serial master: clock parks high, data inverted when released
module frame_host (
	input  wire logic clk,
	output logic      sclk,
	output logic      din,
	output logic      sync_n
);
	initial begin
		sclk = 1'b1;
		din = 1'b0;
		sync_n = 1'b1;
	end

	task automatic send(input logic [15:0] w, input int n);
		@(posedge clk) sync_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk) din <= w[15-i];
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge clk);
		sync_n <= 1'b1;
		din <= ~din;
	endtask
endmodule

// ===== frame_if.sv
`timescale 1ns/10ps

interface frame_if;
	import dac_cmd_pkg::*;

	logic [FRAME_BITS-1:0] word;
	logic                  valid;
	logic                  aborted;

	modport src (
		output word,
		output valid,
		output aborted
	);

	modport snk (
		input word,
		input valid,
		input aborted
	);

endinterface

// ===== octal_dac_command_update_logic.sv
`timescale 1ns/10ps

// Operation
// R1: the top four word bits select the operation
// R2: after reset, channel writes store codes but leave outputs alone
// R3: bit 15 clear means channel write: index 14..12, code 11..0
// R4: code 1001 enters write-through mode, which persists
// R5: code 1000 returns to register-only mode, which persists
// R6: host sends zero payload with either mode change command
// R7: write-through channel writes load stored code and output together
// R8: codes 1010, 1011, 1100 act the same in either mode
// R9: special commands never change the current mode
// R10: code 1010 loads outputs of selected channels from stored codes
// R11: code 1010 bits 11..10: 00 regulator off, 10 on; 9..8 ignored
// R12: code 1011 writes channel one and updates all outputs
// R13: code 1100 writes all channels and updates all outputs
// R14: sixteen bits msb first on sclk falls; executes on frame-select rise
// R15: frame ended before the fifteenth falling edge is discarded
// R16: reset clears shift register and all stored codes to zero
// R17: code 1010 with no channel selected only sets the regulator
module octal_dac_command_update_logic (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              sclk,
	input  wire logic              din,
	input  wire logic              sync_n,
	output dac_cmd_pkg::code_arr_t stored_code,
	output dac_cmd_pkg::code_arr_t output_code,
	output logic [7:0]             output_load,
	output logic [7:0]             output_valid,
	output logic                   write_through_mode,
	output logic                   regulator_enable,
	output dac_cmd_pkg::cmd_e      last_command,
	output logic                   command_done,
	output logic                   command_ignored,
	output logic                   frame_aborted,
	output logic [7:0]             accepted_count,
	output logic [7:0]             aborted_count
);
	import dac_cmd_pkg::*;

	// ==========================================================
	// declarations
	frame_if frm ();

	logic [3:0]        cmd_bits;
	logic              is_channel;
	logic [2:0]        ch_index;
	logic [CODE_W-1:0] payload;
	logic [1:0]        reg_field;
	logic [7:0]        sel_field;

	logic [NUM_CH-1:0] write_mask;
	logic [NUM_CH-1:0] load_mask;
	logic              next_mode;
	logic              next_regulator;
	logic              known;

	// ==========================================================
	// serial frame capture
	serial_frame_rx u_rx (
		.clk    (clk),
		.srst   (srst),
		.sclk   (sclk),
		.din    (din),
		.sync_n (sync_n),
		.frm    (frm)
	);

	// ==========================================================
	// field split
	assign cmd_bits   = frm.word[CMD_MSB:CMD_LSB]; // see R1
	assign is_channel = ~frm.word[KIND_BIT]; // see R3
	assign ch_index   = frm.word[CH_MSB:CH_LSB]; // see R3
	assign payload    = frm.word[CODE_MSB:0]; // see R3
	assign reg_field  = frm.word[REG_HI_BIT:REG_LO_BIT];
	assign sel_field  = frm.word[SEL_MSB:0];

	// ==========================================================
	// decode which registers and outputs change
	always_comb begin
		write_mask = '0;
		load_mask  = '0;
		known      = 1'b0;
		if (frm.valid) begin
			if (is_channel) begin
				known                = 1'b1;
				write_mask[ch_index] = 1'b1; // see R3
				// register-only mode leaves the output untouched
				if (write_through_mode) begin
					load_mask[ch_index] = 1'b1; // see R7
				end
			end else begin
				// special codes ignore the mode on purpose
				unique case (cmd_bits) // see R8
					CMD_REGISTER_ONLY: begin
						known = 1'b1;
					end
					CMD_WRITE_THROUGH: begin
						known = 1'b1;
					end
					CMD_UPDATE_SELECT: begin
						known     = 1'b1;
						// an all-zero select loads nothing
						load_mask = sel_field; // see R10, see R17
					end
					CMD_CHANNEL_ONE: begin
						known         = 1'b1;
						write_mask[0] = 1'b1; // see R12
						load_mask     = '1; // see R12
					end
					CMD_BROADCAST: begin
						known      = 1'b1;
						write_mask = '1; // see R13
						load_mask  = '1; // see R13
					end
					default: begin
						// power-down codes are not handled here
						known = 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// mode and regulator next values
	always_comb begin
		next_mode = write_through_mode;
		if (frm.valid && !is_channel) begin
			// payload of a mode change is not checked; the host owes zeros
			if (cmd_bits == CMD_WRITE_THROUGH) begin
				next_mode = 1'b1; // see R4
			end else if (cmd_bits == CMD_REGISTER_ONLY) begin
				next_mode = 1'b0; // see R5
			end
		end
	end

	always_comb begin
		next_regulator = regulator_enable;
		if (frm.valid && !is_channel && cmd_bits == CMD_UPDATE_SELECT) begin
			// other field values keep the present setting
			if (reg_field == REGULATOR_ON) begin
				next_regulator = 1'b1; // see R11
			end else if (reg_field == REGULATOR_OFF) begin
				next_regulator = 1'b0; // see R11
			end
		end
	end

	// ==========================================================
	// operating mode
	always_ff @(posedge clk) begin
		if (srst) begin
			write_through_mode <= MODE_RST; // see R2
		end else begin
			// special commands fall through unchanged
			write_through_mode <= next_mode; // see R9
		end
	end

	// ==========================================================
	// regulator control
	always_ff @(posedge clk) begin
		if (srst) begin
			regulator_enable <= REG_RST;
		end else begin
			regulator_enable <= next_regulator; // see R11
		end
	end

	// ==========================================================
	// stored channel codes
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				stored_code[i] <= CODE_RST; // see R16
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (write_mask[i]) begin
					stored_code[i] <= payload; // see R3
				end
			end
		end
	end

	// ==========================================================
	// output codes
	// a channel written in the same frame loads the new payload,
	// others load what was stored before the frame
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				output_code[i] <= CODE_RST; // see R16
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (load_mask[i]) begin
					if (write_mask[i]) begin
						output_code[i] <= payload; // see R7, see R13
					end else begin
						output_code[i] <= stored_code[i]; // see R10
					end
				end
			end
		end
	end

	// one-cycle load pulse per channel, in step with output_code
	always_ff @(posedge clk) begin
		if (srst) begin
			output_load <= '0;
		end else begin
			output_load <= load_mask;
		end
	end

	// ==========================================================
	// output valid flags: set once a channel output has been loaded
	always_ff @(posedge clk) begin
		if (srst) begin
			output_valid <= '0;
		end else begin
			output_valid <= output_valid | load_mask;
		end
	end

	// ==========================================================
	// command status
	always_ff @(posedge clk) begin
		if (srst) begin
			command_done    <= 1'b0;
			command_ignored <= 1'b0;
			frame_aborted   <= 1'b0;
		end else begin
			command_done    <= frm.valid && known;
			command_ignored <= frm.valid && !known;
			frame_aborted   <= frm.aborted; // see R15
		end
	end

	// last executed command code; channel writes record their top bits
	always_ff @(posedge clk) begin
		if (srst) begin
			last_command <= CMD_REGISTER_ONLY;
		end else if (frm.valid && known) begin
			last_command <= cmd_e'(cmd_bits);
		end
	end

	// ==========================================================
	// frame counters; they wrap, software compares differences
	always_ff @(posedge clk) begin
		if (srst) begin
			accepted_count <= STAT_RST;
		end else if (frm.valid) begin
			accepted_count <= accepted_count + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			aborted_count <= STAT_RST;
		end else if (frm.aborted) begin
			aborted_count <= aborted_count + 8'h01;
		end
	end

endmodule

// ===== octal_dac_command_update_logic_bench.sv
`timescale 1ns/10ps

module octal_dac_command_update_logic_bench;
	import dac_cmd_pkg::*;
	logic       clk, srst, sclk, din, sync_n, write_through_mode, regulator_enable;
	logic       command_done, command_ignored, frame_aborted, seen_abort = 1'b0;
	logic       seen_ignore = 1'b0;
	logic [7:0] output_load, output_valid, accepted_count, aborted_count;
	code_arr_t  stored_code, output_code, exp_st, exp_out;
	cmd_e       last_command;
	int         n_fail = 0, checks_done = 0, n_frames = 0;

	octal_dac_command_update_logic i_dut (.clk, .srst, .sclk, .din, .sync_n, .stored_code,
		.output_code, .output_load, .output_valid, .write_through_mode, .regulator_enable,
		.last_command, .command_done, .command_ignored, .frame_aborted, .accepted_count,
		.aborted_count);
	frame_host i_host (.clk, .sclk, .din, .sync_n);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// sticky catches for one-cycle pulses, read later by the scenarios
	always @(posedge clk) begin
		if (frame_aborted === 1'b1) seen_abort <= 1'b1;
		if (command_ignored === 1'b1) seen_ignore <= 1'b1;
	end

	// ========
	// shared helpers
	task automatic cmp_codes(input code_arr_t got, input code_arr_t exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: codes %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask
	// outputs settle four cycles after frame-select rises
	task automatic frame(input logic [15:0] w);
		i_host.send(w, 16);
		n_frames++;
		repeat (8) @(posedge clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ========
	// scenarios
	task automatic t_reg_only;
		cmp_codes(stored_code, '0);
		cmp_bit(write_through_mode, 1'b0);
		for (int i = 0; i < 8; i++) begin
			exp_st[i] = 12'h0a5 + 12'h111 * i;
			frame({1'b0, i[2:0], exp_st[i]});
		end
		cmp_codes(stored_code, exp_st);
		cmp_codes(output_code, exp_out);
		cmp_byte(output_valid, 8'h00);
		$display("done t_reg_only");
	endtask
	task automatic t_modes;
		frame(16'h9000);
		cmp_bit(write_through_mode, 1'b1);
		frame(16'h3777);
		exp_st[3] = 12'h777;
		exp_out[3] = 12'h777;
		cmp_codes(output_code, exp_out);
		frame(16'h8000);
		cmp_bit(write_through_mode, 1'b0);
		frame(16'h4123);
		exp_st[4] = 12'h123;
		cmp_codes(output_code, exp_out);
		$display("done t_modes");
	endtask
	task automatic t_select;
		frame(16'ha811);
		exp_out[0] = exp_st[0];
		exp_out[4] = exp_st[4];
		cmp_codes(output_code, exp_out);
		cmp_bit(regulator_enable, 1'b1);
		frame(16'ha300);
		cmp_codes(output_code, exp_out);
		cmp_bit(regulator_enable, 1'b0);
		cmp_byte(output_valid, 8'h19);
		$display("done t_select");
	endtask
	task automatic t_ch1_bcast;
		frame(16'h1bcd);
		exp_st[1] = 12'hbcd;
		frame(16'hb321);
		exp_st[0] = 12'h321;
		exp_out = exp_st;
		cmp_codes(output_code, exp_out);
		cmp_bit(write_through_mode, 1'b0);
		frame(16'h9000);
		frame(16'hc5a5);
		for (int i = 0; i < 8; i++) exp_st[i] = 12'h5a5;
		exp_out = exp_st;
		cmp_codes(stored_code, exp_st);
		cmp_codes(output_code, exp_out);
		cmp_bit(write_through_mode, 1'b1);
		cmp_byte(output_valid, 8'hff);
		$display("done t_ch1_bcast");
	endtask
	task automatic t_abort_ignore;
		i_host.send(16'h7fff, 10);
		repeat (8) @(posedge clk);
		cmp_codes(stored_code, exp_st);
		cmp_bit(seen_abort, 1'b1);
		cmp_codes(output_code, exp_out);
		cmp_bit(seen_ignore, 1'b0);
		frame(16'hd0ff);
		cmp_codes(output_code, exp_out);
		cmp_codes(stored_code, exp_st);
		cmp_bit(seen_ignore, 1'b1);
		cmp_byte({4'h0, last_command}, {4'h0, CMD_BROADCAST});
		cmp_byte(accepted_count, n_frames[7:0]);
		cmp_byte(aborted_count, 8'h01);
		$display("done t_abort_ignore");
	endtask
	// reset in mid-run, from write-through mode with the regulator on
	task automatic t_reset;
		frame(16'ha800);
		cmp_bit(regulator_enable, 1'b1);
		cmp_codes(output_code, exp_out);
		srst <= 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		exp_st = '0;
		exp_out = '0;
		n_frames = 0;
		cmp_codes(stored_code, exp_st);
		cmp_codes(output_code, exp_out);
		cmp_bit(write_through_mode, 1'b0);
		cmp_bit(regulator_enable, 1'b0);
		cmp_byte(output_valid, 8'h00);
		cmp_byte(accepted_count, 8'h00);
		cmp_byte(aborted_count, 8'h00);
		frame(16'h2abc);
		exp_st[2] = 12'habc;
		cmp_codes(stored_code, exp_st);
		cmp_codes(output_code, exp_out);
		cmp_byte(accepted_count, n_frames[7:0]);
		$display("done t_reset");
	endtask

	initial begin
		#2000000;
		n_fail++;
		wrap_up();
	end
	initial begin
		srst = 1'b1;
		exp_st = '0;
		exp_out = '0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		t_reg_only();
		t_modes();
		t_select();
		t_ch1_bcast();
		t_abort_ignore();
		t_reset();
		wrap_up();
	end
endmodule

// ===== serial_frame_rx.sv
`timescale 1ns/10ps

module serial_frame_rx (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic sclk,
	input  wire logic din,
	input  wire logic sync_n,
	frame_if.src      frm
);
	import dac_cmd_pkg::*;

	logic                  sclk_meta, sclk_s, sclk_d;
	logic                  din_meta, din_s;
	logic                  sync_meta, sync_s, sync_d;
	logic [FRAME_BITS-1:0] shift;
	logic [EDGE_CNT_W-1:0] edges;
	logic                  sclk_fall;
	logic                  sync_rise;

	// ==========================================================
	// pin synchronisers; first stages feed only second stages
	always_ff @(posedge clk) begin
		sclk_meta <= sclk;
		sclk_s    <= sclk_meta;
		sclk_d    <= sclk_s;
		din_meta  <= din;
		din_s     <= din_meta;
		sync_meta <= sync_n;
		sync_s    <= sync_meta;
		sync_d    <= sync_s;
	end

	// din and sclk share the same delay, so din is sampled in step
	assign sclk_fall = sclk_d & ~sclk_s & ~sync_s;
	assign sync_rise = ~sync_d & sync_s;

	// ==========================================================
	// shift register, msb first
	always_ff @(posedge clk) begin
		if (srst) begin
			shift <= WORD_RST; // see R16
		end else if (sclk_fall) begin
			shift <= {shift[FRAME_BITS-2:0], din_s}; // see R14
		end
	end

	// edge count saturates so long frames cannot wrap into aborts
	always_ff @(posedge clk) begin
		if (srst || sync_rise) begin
			edges <= EDGES_RST;
		end else if (sclk_fall && edges != 5'h1f) begin
			edges <= edges + 5'h01;
		end
	end

	// ==========================================================
	// frame end: execute or discard
	always_ff @(posedge clk) begin
		if (srst) begin
			frm.valid   <= 1'b0;
			frm.aborted <= 1'b0;
			frm.word    <= WORD_RST;
		end else begin
			frm.valid   <= sync_rise && edges >= EDGE_CNT_W'(MIN_EDGES); // see R14
			frm.aborted <= sync_rise && edges < EDGE_CNT_W'(MIN_EDGES); // see R15
			if (sync_rise) begin
				frm.word <= shift;
			end
		end
	end

endmodule
